// ---- data_memory_pkg.sv ----
// Package with the data memory map, layouts and reset values
package data_memory_pkg;

  // ==========================================================
  // Widths
  localparam int DATA_W = 8;
  localparam int GP_DEPTH = 256;
  localparam int PROG_W = 16;

  // ==========================================================
  // Special-function register offsets
  localparam logic [7:0] ADDR_INDIRECT_PORT_ZERO = 8'h00;
  localparam logic [7:0] ADDR_POINTER_ZERO = 8'h01;
  localparam logic [7:0] ADDR_INDIRECT_PORT_ONE = 8'h02;
  localparam logic [7:0] ADDR_POINTER_ONE = 8'h03;
  localparam logic [7:0] ADDR_BANK_SELECT = 8'h04;
  localparam logic [7:0] ADDR_WORKING_REGISTER = 8'h05;
  localparam logic [7:0] ADDR_PROGRAM_COUNTER_LOW = 8'h06;
  localparam logic [7:0] ADDR_TABLE_POINTER_LOW = 8'h07;
  localparam logic [7:0] ADDR_TABLE_HIGH_BYTE = 8'h08;
  localparam logic [7:0] ADDR_TABLE_POINTER_HIGH = 8'h09;
  localparam logic [7:0] ADDR_NVM_CONTROL = 8'h40;

  // ==========================================================
  // General-purpose windows
  localparam logic [7:0] SMALL_GP_FIRST = 8'h40;
  localparam logic [7:0] SMALL_GP_LAST = 8'hdf;
  localparam logic [7:0] LARGE_GP_FIRST = 8'h80;

  // ==========================================================
  // Fields and reset values
  localparam int BANK_SELECT_BIT_POS = 0;
  localparam logic [7:0] BANK_SELECT_RST = 8'h00;
  localparam logic [7:0] POINTER_RST = 8'h00;
  localparam logic [7:0] WORKING_REGISTER_RST = 8'h00;
  localparam logic [7:0] TABLE_RST = 8'h00;
  localparam logic [7:0] NVM_CONTROL_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ==========================================================
  // Table read sequencer
  typedef enum logic [0:0] {
    TBL_IDLE = 1'b0,
    TBL_FETCH = 1'b1
  } tbl_state_t;

endpackage

// ---- data_memory_bank.sv ----
// Banked data memory with indirect ports, working register and table registers
`timescale 1ns/1ps
// Contract
// - Data memory is 8-bit volatile storage: special-function area plus read/write RAM
// - Two banks; special registers shared, nvm control at 40H only in bank 1
// - Address space starts at 00H with special registers lowest
// - Small variant: registers 00H-3FH, 160 RAM bytes 40H-DFH bank 0 only
// - Large variant: 128 RAM bytes at 80H-FFH in each bank
// - Unused special-function locations read zero
// - Fixed map: ports 00H/02H, pointers 01H/03H, bank 04H, working 05H, pc 06H
// - Indirect port access acts on location held in its pointer, not itself
// - Port zero reaches bank 0 only; port one reaches the selected bank
// - Pointer aimed at an indirect port reads 00H and ignores writes
// - Both pointers are real read/write registers
// - Direct accesses always go to bank 0; bank 1 only via port one
// - Bank chosen by bit 0 of bank select; bits 7-1 read zero
// - Reset clears bank select, except watchdog time-out reset in power-down
// - ALU results land in working register; no direct register moves
// - Program counter low byte is readable in data space
// - Writing pc low jumps within page and inserts one dummy cycle; a table read into pc low loads the value with no jump
// - Software loads table pointers first; they stay writable and incrementable (this block only writes them; nothing increments them)
// - Table read puts high byte in table-high, low byte at named location
// - Each table read takes two instruction cycles
// - Unimplemented bits of fetched high byte read zero
module data_memory_bank #(
  parameter bit large_variant_p = 1'b0,
  parameter logic [data_memory_pkg::PROG_W-1:0] prog_word_mask_p = 16'h3fff
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic wdt_pd_reset_in,
  // Data memory access from the core
  input wire logic [7:0] mem_addr_in,
  input wire logic mem_rd_in,
  input wire logic mem_wr_in,
  input wire logic [data_memory_pkg::DATA_W-1:0] mem_wdata_in,
  output logic [data_memory_pkg::DATA_W-1:0] mem_rdata_out,
  // ALU result path
  input wire logic alu_we_in,
  input wire logic [data_memory_pkg::DATA_W-1:0] alu_result_in,
  output logic [data_memory_pkg::DATA_W-1:0] working_register_out,
  // Program counter low byte
  input wire logic [7:0] pc_low_in,
  output logic pc_load_out,
  output logic [7:0] pc_load_value_out,
  output logic dummy_cycle_out,
  // Table read
  input wire logic tbl_start_in,
  input wire logic [7:0] tbl_dest_addr_in,
  input wire logic [data_memory_pkg::PROG_W-1:0] prog_word_in,
  output logic prog_rd_out,
  output logic [data_memory_pkg::PROG_W-1:0] prog_addr_out,
  output logic tbl_busy_out,
  output logic tbl_done_out,
  // Bank-1 nvm control byte
  output logic [data_memory_pkg::DATA_W-1:0] nvm_control_out
);
  import data_memory_pkg::*;

  // ==========================================================
  // Storage
  logic [DATA_W-1:0] ram_r [0:GP_DEPTH-1];
  logic [7:0] pointer_zero_r;
  logic [7:0] pointer_one_r;
  logic bank_select_bit_r;
  logic [7:0] working_register_r;
  logic [7:0] table_pointer_low_r;
  logic [7:0] table_pointer_high_r;
  logic [7:0] table_high_byte_r;
  logic [7:0] nvm_control_r;
  tbl_state_t tbl_state_r;
  logic [7:0] tbl_dest_r;
  logic pc_load_r;
  logic tbl_busy_r;

  // ==========================================================
  // Address resolution: {null, bank, address}
  function automatic logic [9:0] resolve(input logic [7:0] a, input logic [7:0] p0,
                                         input logic [7:0] p1, input logic bsel);
    logic [7:0] t;
    logic b;
    logic ind;
    t = a;
    b = 1'b0;
    ind = 1'b0;
    if (a == ADDR_INDIRECT_PORT_ZERO) begin
      t = p0;
      b = 1'b0;
      ind = 1'b1;
    end else if (a == ADDR_INDIRECT_PORT_ONE) begin
      t = p1;
      b = bsel;
      ind = 1'b1;
    end
    resolve = {ind && (t == ADDR_INDIRECT_PORT_ZERO || t == ADDR_INDIRECT_PORT_ONE), b, t};
  endfunction

  // General-purpose hit test, returns {hit, index}
  function automatic logic [8:0] gp_lookup(input logic b, input logic [7:0] a);
    logic hit;
    logic [7:0] idx;
    if (large_variant_p) begin
      hit = (a >= LARGE_GP_FIRST);
      idx = {b, a[6:0]};
    end else begin
      hit = !b && (a >= SMALL_GP_FIRST) && (a <= SMALL_GP_LAST);
      idx = a - SMALL_GP_FIRST;
    end
    gp_lookup = {hit, idx};
  endfunction

  // ==========================================================
  // Access decode
  logic [9:0] rd_tgt;
  logic [9:0] wr_tgt;
  logic [8:0] rd_gp;
  logic [8:0] wr_gp;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_val;
  logic tbl_write;

  assign tbl_write = (tbl_state_r == TBL_FETCH);
  assign rd_tgt = resolve(mem_addr_in, pointer_zero_r, pointer_one_r, bank_select_bit_r);
  assign wr_tgt = resolve(tbl_write ? tbl_dest_r : mem_addr_in, pointer_zero_r,
                          pointer_one_r, bank_select_bit_r);
  assign rd_gp = gp_lookup(rd_tgt[8], rd_tgt[7:0]);
  assign wr_gp = gp_lookup(wr_tgt[8], wr_tgt[7:0]);
  assign wr_en = (tbl_write || mem_wr_in) && !wr_tgt[9];
  assign wr_data = tbl_write ? prog_word_in[7:0] : mem_wdata_in;

  // Read multiplexer
  always_comb begin
    rd_val = READ_ZERO;
    if (rd_tgt[9]) begin
      rd_val = READ_ZERO;
    end else if (rd_gp[8]) begin
      rd_val = ram_r[rd_gp[7:0]];
    end else if (rd_tgt[8] && rd_tgt[7:0] == ADDR_NVM_CONTROL) begin
      rd_val = nvm_control_r;
    end else begin
      unique case (rd_tgt[7:0])
        ADDR_POINTER_ZERO: rd_val = pointer_zero_r;
        ADDR_POINTER_ONE: rd_val = pointer_one_r;
        ADDR_BANK_SELECT: rd_val = {7'h00, bank_select_bit_r};
        ADDR_WORKING_REGISTER: rd_val = working_register_r;
        ADDR_PROGRAM_COUNTER_LOW: rd_val = pc_low_in;
        ADDR_TABLE_POINTER_LOW: rd_val = table_pointer_low_r;
        ADDR_TABLE_HIGH_BYTE: rd_val = table_high_byte_r;
        ADDR_TABLE_POINTER_HIGH: rd_val = table_pointer_high_r;
        default: rd_val = READ_ZERO;
      endcase
    end
  end

  // Shared registers answer in either bank, so only the low address is compared
  function automatic logic hits(input logic [7:0] t, input logic [7:0] a);
    hits = (t == a);
  endfunction

  // ==========================================================
  // Write strobes, null targets already removed by wr_en
  logic wr_ptr0;
  logic wr_ptr1;
  logic wr_bank;
  logic wr_work;
  logic wr_pcl;
  logic wr_tblp;
  logic wr_tbhp;
  logic wr_nvm;

  assign wr_ptr0 = wr_en && hits(wr_tgt[7:0], ADDR_POINTER_ZERO);
  assign wr_ptr1 = wr_en && hits(wr_tgt[7:0], ADDR_POINTER_ONE);
  assign wr_bank = wr_en && hits(wr_tgt[7:0], ADDR_BANK_SELECT);
  assign wr_work = wr_en && hits(wr_tgt[7:0], ADDR_WORKING_REGISTER);
  assign wr_pcl = wr_en && hits(wr_tgt[7:0], ADDR_PROGRAM_COUNTER_LOW);
  assign wr_tblp = wr_en && hits(wr_tgt[7:0], ADDR_TABLE_POINTER_LOW);
  assign wr_tbhp = wr_en && hits(wr_tgt[7:0], ADDR_TABLE_POINTER_HIGH);
  // Only bank 1 holds the nvm control byte at this address
  assign wr_nvm = wr_en && wr_tgt[8] && (wr_tgt[7:0] == ADDR_NVM_CONTROL);

  // ==========================================================
  // General-purpose RAM
  always_ff @(posedge clk_sys_in) begin
    if (wr_en && wr_gp[8]) begin
      ram_r[wr_gp[7:0]] <= wr_data;
    end
  end

  // ==========================================================
  // Pointers
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pointer_zero_r <= POINTER_RST;
      pointer_one_r <= POINTER_RST;
    end else begin
      if (wr_ptr0) begin
        pointer_zero_r <= wr_data;
      end
      if (wr_ptr1) begin
        pointer_one_r <= wr_data;
      end
    end
  end

  // ==========================================================
  // Bank select
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      if (!wdt_pd_reset_in) begin
        bank_select_bit_r <= BANK_SELECT_RST[BANK_SELECT_BIT_POS];
      end
    end else if (wr_bank) begin
      bank_select_bit_r <= wr_data[BANK_SELECT_BIT_POS];
    end
  end

  // ==========================================================
  // Working register, ALU result has priority
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      working_register_r <= WORKING_REGISTER_RST;
    end else if (alu_we_in) begin
      working_register_r <= alu_result_in;
    end else if (wr_work) begin
      working_register_r <= wr_data;
    end
  end

  assign working_register_out = working_register_r;

  // ==========================================================
  // Program counter low write: jump then dummy cycle
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pc_load_r <= 1'b0;
      pc_load_value_out <= READ_ZERO;
      dummy_cycle_out <= 1'b0;
    end else begin
      // A table read landing on the pc low byte updates the value without a jump
      pc_load_r <= !tbl_write && wr_pcl;
      if (wr_pcl) begin
        pc_load_value_out <= wr_data;
      end
      dummy_cycle_out <= pc_load_r;
    end
  end

  assign pc_load_out = pc_load_r;

  // ==========================================================
  // Table pointers
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      table_pointer_low_r <= TABLE_RST;
      table_pointer_high_r <= TABLE_RST;
    end else begin
      if (wr_tblp) begin
        table_pointer_low_r <= wr_data;
      end
      if (wr_tbhp) begin
        table_pointer_high_r <= wr_data;
      end
    end
  end

  // ==========================================================
  // Table read sequencer, two cycles
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      tbl_state_r <= TBL_IDLE;
      tbl_dest_r <= TABLE_RST;
      prog_rd_out <= 1'b0;
      prog_addr_out <= {TABLE_RST, TABLE_RST};
      tbl_done_out <= 1'b0;
      tbl_busy_r <= 1'b0;
    end else begin
      tbl_done_out <= 1'b0;
      prog_rd_out <= 1'b0;
      tbl_busy_r <= 1'b0;
      unique case (tbl_state_r)
        TBL_IDLE: begin
          if (tbl_start_in) begin
            tbl_state_r <= TBL_FETCH;
            tbl_dest_r <= tbl_dest_addr_in;
            prog_rd_out <= 1'b1;
            tbl_busy_r <= 1'b1;
            prog_addr_out <= {table_pointer_high_r, table_pointer_low_r};
          end
        end
        TBL_FETCH: begin
          tbl_state_r <= TBL_IDLE;
          tbl_done_out <= 1'b1;
        end
      endcase
    end
  end

  assign tbl_busy_out = tbl_busy_r;

  // Table-high byte, written only by table reads
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      table_high_byte_r <= TABLE_RST;
    end else if (tbl_write) begin
      table_high_byte_r <= prog_word_in[15:8] & prog_word_mask_p[15:8];
    end
  end

  // ==========================================================
  // Nvm control byte, bank 1 only
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      nvm_control_r <= NVM_CONTROL_RST;
    end else if (wr_nvm) begin
      nvm_control_r <= wr_data;
    end
  end

  assign nvm_control_out = nvm_control_r;

  // ==========================================================
  // Registered read data
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      mem_rdata_out <= READ_ZERO;
    end else if (mem_rd_in) begin
      mem_rdata_out <= rd_val;
    end
  end

endmodule // data_memory_bank

// ---- banked_data_memory_indirect_properties.sv ----
// Port checker for the banked data memory
`timescale 1ns/1ps
// ==========
// Checker
module banked_data_memory_indirect_properties (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Data bus and working register
  input wire logic [7:0] mem_addr_in,
  input wire logic mem_rd_in,
  input wire logic mem_wr_in,
  input wire logic [7:0] mem_wdata_in,
  input wire logic [7:0] mem_rdata_out,
  input wire logic alu_we_in,
  input wire logic [7:0] alu_result_in,
  input wire logic [7:0] working_register_out,
  // Program counter and table read
  input wire logic [7:0] pc_low_in,
  input wire logic pc_load_out,
  input wire logic [7:0] pc_load_value_out,
  input wire logic dummy_cycle_out,
  input wire logic tbl_start_in,
  input wire logic prog_rd_out,
  input wire logic tbl_busy_out,
  input wire logic tbl_done_out
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);
  property p_pc_load;
    mem_wr_in && mem_addr_in == 8'h06 && !tbl_busy_out
      |=> pc_load_out && pc_load_value_out == $past(mem_wdata_in);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("jump not issued");
  property p_dummy;
    pc_load_out |=> dummy_cycle_out ##1 (dummy_cycle_out == $past(pc_load_out));
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy cycle wrong");
  property p_tbl_seq;
    tbl_start_in && !tbl_busy_out
      |=> prog_rd_out && tbl_busy_out ##1 tbl_done_out && !prog_rd_out;
  endproperty
  a_tbl_seq: assert property (p_tbl_seq) else $error("table read not two cycles");
  property p_busy_one;
    tbl_busy_out |=> !tbl_busy_out;
  endproperty
  a_busy_one: assert property (p_busy_one) else $error("busy too long");
  property p_alu;
    alu_we_in |=> working_register_out == $past(alu_result_in);
  endproperty
  a_alu: assert property (p_alu) else $error("alu result lost");
  property p_unused;
    mem_rd_in && mem_addr_in inside {[8'h0a:8'h3f]} |=> mem_rdata_out == 8'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused not zero");
  property p_bank_bits;
    mem_rd_in && mem_addr_in == 8'h04 |=> mem_rdata_out[7:1] == 7'h00;
  endproperty
  a_bank_bits: assert property (p_bank_bits) else $error("bank bits set");
  property p_pc_read;
    mem_rd_in && mem_addr_in == 8'h06 |=> mem_rdata_out == $past(pc_low_in);
  endproperty
  a_pc_read: assert property (p_pc_read) else $error("pc low read wrong");
  c_pc_load: cover property (pc_load_out);
  c_tbl: cover property (tbl_done_out);
  c_alu: cover property (alu_we_in);
endmodule // banked_data_memory_indirect_properties
bind data_memory_bank banked_data_memory_indirect_properties chk (.*);

// ---- prog_memory_model.sv ----
// Program memory model answering table fetches
`timescale 1ns/1ps
// ==========
// Program memory
module prog_memory_model (
  // Clock
  input wire logic clk_sys_in,
  // Fetch from the block
  input wire logic prog_rd_in,
  input wire logic [15:0] prog_addr_in,
  output logic [15:0] prog_word_out
);
  logic [15:0] junk_r = 16'ha5c3;
  always_ff @(posedge clk_sys_in) begin
    junk_r <= junk_r + 16'h1357;
  end
  // Word valid only during the fetch, junk otherwise
  always_comb begin
    prog_word_out = prog_rd_in ? {~prog_addr_in[7:0], prog_addr_in[15:8]} : junk_r;
  end
endmodule // prog_memory_model

// ---- tb_banked_data_memory_indirect.sv ----
// Testbench for the banked data memory
`timescale 1ns/1ps
// ==========
// Testbench
module tb_banked_data_memory_indirect;
  import data_memory_pkg::*;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic wdt = 1'b0;
  logic rd = 1'b0, wr = 1'b0, alu_we = 1'b0, start = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, alu_res = 8'h00, pc_low = 8'h00, dest = 8'h00;
  logic [7:0] rdata, wreg, pc_val, nvm;
  logic [7:0] rdata_l;
  logic pc_load, dummy, prog_rd, busy, done;
  logic [15:0] prog_addr, prog_word;
  int error_cnt = 0, cmp_count = 0, cycles = 0;
  data_memory_bank dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .wdt_pd_reset_in(wdt), .mem_addr_in(addr), .mem_rd_in(rd), .mem_wr_in(wr),
    .mem_wdata_in(wdata), .mem_rdata_out(rdata), .alu_we_in(alu_we),
    .alu_result_in(alu_res), .working_register_out(wreg), .pc_low_in(pc_low),
    .pc_load_out(pc_load), .pc_load_value_out(pc_val), .dummy_cycle_out(dummy),
    .tbl_start_in(start), .tbl_dest_addr_in(dest), .prog_word_in(prog_word),
    .prog_rd_out(prog_rd), .prog_addr_out(prog_addr), .tbl_busy_out(busy),
    .tbl_done_out(done), .nvm_control_out(nvm));
  data_memory_bank #(.large_variant_p(1'b1)) dut_large (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .wdt_pd_reset_in(wdt), .mem_addr_in(addr), .mem_rd_in(rd),
    .mem_wr_in(wr), .mem_wdata_in(wdata), .mem_rdata_out(rdata_l), .alu_we_in(alu_we),
    .alu_result_in(alu_res), .working_register_out(), .pc_low_in(pc_low),
    .pc_load_out(), .pc_load_value_out(), .dummy_cycle_out(), .tbl_start_in(start),
    .tbl_dest_addr_in(dest), .prog_word_in(prog_word), .prog_rd_out(), .prog_addr_out(),
    .tbl_busy_out(), .tbl_done_out(), .nvm_control_out());
  prog_memory_model pmem (.clk_sys_in(clk_sys_in), .prog_rd_in(prog_rd),
    .prog_addr_in(prog_addr), .prog_word_out(prog_word));
  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    @(posedge clk_sys_in);
    chk("read data", exp, rdata);
  endtask
  task automatic reset_dut(input logic keep);
    wdt <= keep;
    sys_rst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    wdt <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  // Start held into the busy cycle must be ignored
  task automatic tbl_read(input logic [7:0] lo, input logic [7:0] d);
    wr_reg(ADDR_TABLE_POINTER_LOW, lo);
    dest <= d;
    start <= 1'b1;
    @(posedge clk_sys_in);
    #1;
    chk("fetch address", {8'h12, lo}, prog_addr);
    chk("busy", 1'b1, busy);
    chk("program read", 1'b1, prog_rd);
    @(posedge clk_sys_in);
    start <= 1'b0;
    #1;
    chk("done", 1'b1, done);
    @(posedge clk_sys_in);
    rd_reg(ADDR_TABLE_HIGH_BYTE, ~lo & 8'h3f);
    rd_reg(d, 8'h12);
  endtask
  initial begin
    reset_dut(1'b0);
    rd_reg(ADDR_BANK_SELECT, BANK_SELECT_RST);
    wr_reg(ADDR_POINTER_ZERO, 8'h40);
    rd_reg(ADDR_POINTER_ZERO, 8'h40);
    wr_reg(8'h40, 8'h11);
    wr_reg(8'hdf, 8'h22);
    rd_reg(8'hdf, 8'h22);
    rd_reg(ADDR_INDIRECT_PORT_ZERO, 8'h11);
    wr_reg(ADDR_INDIRECT_PORT_ZERO, 8'h33);
    rd_reg(8'h40, 8'h33);
    wr_reg(8'h3f, 8'h5a);
    rd_reg(8'h3f, 8'h00);
    wr_reg(ADDR_BANK_SELECT, 8'hff);
    rd_reg(ADDR_BANK_SELECT, 8'h01);
    wr_reg(ADDR_POINTER_ONE, ADDR_NVM_CONTROL);
    wr_reg(ADDR_INDIRECT_PORT_ONE, 8'h5a);
    chk("nvm control", 8'h5a, nvm);
    rd_reg(8'h40, 8'h33);
    rd_reg(ADDR_INDIRECT_PORT_ZERO, 8'h33);
    wr_reg(ADDR_POINTER_ONE, ADDR_INDIRECT_PORT_ONE);
    wr_reg(ADDR_INDIRECT_PORT_ONE, 8'h77);
    rd_reg(ADDR_INDIRECT_PORT_ONE, 8'h00);
    wr_reg(ADDR_POINTER_ONE, ADDR_WORKING_REGISTER);
    wr_reg(ADDR_INDIRECT_PORT_ONE, 8'h6b);
    rd_reg(ADDR_WORKING_REGISTER, 8'h6b);
    wr_reg(ADDR_POINTER_ONE, 8'h80);
    wr_reg(ADDR_INDIRECT_PORT_ONE, 8'hc7);
    wr_reg(8'h80, 8'h1e);
    rd_reg(ADDR_INDIRECT_PORT_ONE, 8'h00);
    chk("large bank one", 8'hc7, rdata_l);
    rd_reg(8'h80, 8'h1e);
    chk("large bank zero", 8'h1e, rdata_l);
    reset_dut(1'b1);
    rd_reg(ADDR_BANK_SELECT, 8'h01);
    reset_dut(1'b0);
    rd_reg(ADDR_BANK_SELECT, 8'h00);
    alu_res <= 8'h3c;
    alu_we <= 1'b1;
    @(posedge clk_sys_in);
    alu_we <= 1'b0;
    @(posedge clk_sys_in);
    chk("working register", 8'h3c, wreg);
    rd_reg(ADDR_WORKING_REGISTER, 8'h3c);
    pc_low <= 8'h9e;
    rd_reg(ADDR_PROGRAM_COUNTER_LOW, 8'h9e);
    wr_reg(ADDR_PROGRAM_COUNTER_LOW, 8'h21);
    chk("jump offset", 8'h21, pc_val);
    #1;
    chk("dummy cycle", 1'b1, dummy);
    chk("jump strobe", 1'b0, pc_load);
    @(posedge clk_sys_in);
    wr_reg(ADDR_POINTER_ZERO, 8'h40);
    wr_reg(ADDR_TABLE_POINTER_HIGH, 8'h12);
    tbl_read(8'h34, 8'h50);
    tbl_read(8'h35, ADDR_INDIRECT_PORT_ZERO);
    rd_reg(8'h40, 8'h12);
    wr_reg(ADDR_TABLE_HIGH_BYTE, 8'hff);
    rd_reg(ADDR_TABLE_HIGH_BYTE, 8'h0a);
    results();
  end
endmodule // tb_banked_data_memory_indirect
